// File: logic/daef_dev.sv
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module daef_dev (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  daef_link_if.dev link,
  output logic [63:0] sample_o,
  output logic sample_valid_o,
  output logic alarm_collision_o,
  output logic alarm_one_away_o,
  output logic alarm_two_away_o
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [daef_pkg::DEPTH-1:0][daef_pkg::SAMP_W-1:0] mem;
    logic clk_s1;
    logic clk_s2;
    logic clk_d;
    logic [daef_pkg::DATA_W-1:0] dat_s1;
    logic [daef_pkg::DATA_W-1:0] dat_s2;
    logic [daef_pkg::DATA_W-1:0] half_lo;
    logic in_stb_s1;
    logic in_stb_s2;
    logic fs_s1;
    logic fs_s2;
    logic out_stb_s1;
    logic out_stb_s2;
    logic out_stb_d;
    logic wsync_d;
    logic sw_d;
    logic wsync_pend;
    logic out_stb_pend;
    logic sw_pend;
    logic [daef_pkg::PTR_W-1:0] wr_ptr;
    logic [daef_pkg::PTR_W-1:0] rd_ptr;
    logic [3:0] rd_cnt;
    logic [daef_pkg::SAMP_W-1:0] byp;
    logic [daef_pkg::SAMP_W-1:0] sample;
    logic valid;
    logic coll;
    logic one;
    logic two;
  } daef_dev_st_t;

  daef_dev_st_t st_r;
  daef_dev_st_t st_nxt;

  // shortest distance between two pointers, modulo eight
  function automatic logic [2:0] ptr_gap(input logic [2:0] a, input logic [2:0] b);
    logic [2:0] d;
    d = 3'(a - b);
    ptr_gap = (d > 3'h4) ? 3'(b - a) : d;
  endfunction

  // ----------------------------------------
  // decode of control words
  // ----------------------------------------
  logic ena;
  logic sw_mode;
  logic rd_from_wsync;
  logic rd_from_out_stb;
  logic rise;
  logic fall;
  logic wlvl;
  logic wev;
  logic sw_rise;
  logic out_stb_rise;
  logic tick;
  logic rd_rst;
  logic [2:0] rp;
  logic [2:0] gap;
  logic [63:0] word;

  // mode flags from the enable bit and the select fields
  always_comb begin
    ena = link.fifo_ena;
    sw_mode = (link.sel_in == daef_pkg::SEL_SW_MODE) &&
              (link.sel_out == daef_pkg::SEL_SW_MODE);
    rd_from_wsync = (link.sel_out[3:2] == 2'h0) &&
                    (link.sel_out[1:0] != 2'h0);
    rd_from_out_stb = link.sel_out[daef_pkg::SEL_OUT_STB] &&
                   !link.sel_out[daef_pkg::SEL_SW];
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    rise = 1'b0;
    fall = 1'b0;
    wlvl = 1'b0;
    wev = 1'b0;
    sw_rise = 1'b0;
    out_stb_rise = 1'b0;
    tick = 1'b0;
    rd_rst = 1'b0;
    rp = st_r.rd_ptr;
    gap = 3'h0;
    word = '0;
    if (srst_i) begin
      st_nxt = '0;
      st_nxt.wr_ptr = daef_pkg::OFFSET_RST;
      st_nxt.rd_ptr = daef_pkg::RD_PTR_RST;
    end else if (ce_i) begin
      // pin synchronisers, first stage read only by the second
      st_nxt.clk_s1 = link.source_ddr_clock;
      st_nxt.clk_s2 = st_r.clk_s1;
      st_nxt.clk_d = st_r.clk_s2;
      st_nxt.dat_s1 = link.data;
      st_nxt.dat_s2 = st_r.dat_s1;
      st_nxt.in_stb_s1 = link.input_strobe;
      st_nxt.in_stb_s2 = st_r.in_stb_s1;
      st_nxt.fs_s1 = link.frame_sync;
      st_nxt.fs_s2 = st_r.fs_s1;
      st_nxt.out_stb_s1 = link.output_strobe;
      st_nxt.out_stb_s2 = st_r.out_stb_s1;
      st_nxt.out_stb_d = st_r.out_stb_s2;
      st_nxt.sw_d = link.sw_sync;
      st_nxt.valid = 1'b0;

      // data clock edges seen on the synchronised clock
      rise = st_r.clk_s2 && !st_r.clk_d;
      fall = !st_r.clk_s2 && st_r.clk_d;

      // write side sync: strobe syncs taken only at data clock rise, software sync on any cycle
      wlvl = (link.sel_in[daef_pkg::SEL_IN_STB] && st_r.in_stb_s2) ||
             (link.sel_in[daef_pkg::SEL_FSYNC] && st_r.fs_s2);
      wev = ena && rise && wlvl && !st_r.wsync_d;
      sw_rise = ena && sw_mode && link.sw_sync && !st_r.sw_d;
      if (rise) begin
        st_nxt.half_lo = st_r.dat_s2;
        st_nxt.wsync_d = wlvl;
      end

      // second half completes the sample: d c b a
      if (fall) begin
        word = {st_r.dat_s2[31:16], st_r.half_lo[31:16],
                st_r.dat_s2[15:0], st_r.half_lo[15:0]};
        if (ena) begin
          st_nxt.mem[st_r.wr_ptr] = word;
          st_nxt.wr_ptr = 3'(st_r.wr_ptr + 3'h1);
        end else begin
          st_nxt.byp = word;
        end
      end

      // write pointer back to its reset position
      if (wev || sw_rise) begin
        st_nxt.wr_ptr = link.fifo_offset;
      end

      // read side output clock: one tick per rd_div converter clocks
      tick = (st_r.rd_cnt == 4'(link.rd_div - 4'h1));
      st_nxt.rd_cnt = tick ? 4'h0 : 4'(st_r.rd_cnt + 4'h1);

      // output strobe sampled on the converter clock
      out_stb_rise = ena && rd_from_out_stb && st_r.out_stb_s2 && !st_r.out_stb_d;

      // read resets wait for the next output clock tick; set beats clear
      st_nxt.wsync_pend = (st_r.wsync_pend && !tick) || (wev && rd_from_wsync);
      st_nxt.out_stb_pend = (st_r.out_stb_pend && !tick) || out_stb_rise;
      st_nxt.sw_pend = (st_r.sw_pend && !tick) || sw_rise;

      if (tick) begin
        rd_rst = st_r.wsync_pend || st_r.out_stb_pend || st_r.sw_pend;
        rp = rd_rst ? daef_pkg::RD_PTR_RST : st_r.rd_ptr;
        st_nxt.valid = 1'b1;
        if (ena) begin
          st_nxt.sample = st_r.mem[rp];
          st_nxt.rd_ptr = 3'(rp + 3'h1);
          gap = ptr_gap(st_r.wr_ptr, rp);
          st_nxt.coll = (gap == 3'h0);
          st_nxt.one = (gap == 3'h1);
          st_nxt.two = (gap == 3'h2);
        end else begin
          st_nxt.sample = st_r.byp;
          st_nxt.coll = 1'b0;
          st_nxt.one = 1'b0;
          st_nxt.two = 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // state update, synchronous reset folded into st_nxt
  always_ff @(posedge mclk_i) begin
    st_r <= st_nxt;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // every output straight from a state bit
  assign sample_o = st_r.sample;
  assign sample_valid_o = st_r.valid;
  assign alarm_collision_o = st_r.coll;
  assign alarm_one_away_o = st_r.one;
  assign alarm_two_away_o = st_r.two;
  assign link.alarm_collision = st_r.coll;
  assign link.alarm_one_away = st_r.one;
  assign link.alarm_two_away = st_r.two;

endmodule
`default_nettype wire

// File: logic/daef_pkg.sv
// What this block does
// - eight entry buffer of four 16-bit channels
// - two 32-bit halves per data clock
// - read 64-bit samples at divided converter rate
// - pointers advance after each write or read
// - pointer reset: read 0, write 4
// - three-bit offset sets write reset position
// - write sync chosen, sampled on data-clock rise
// - write sync recaptured to reset read pointer
// - output strobe resets read pointer independently
// - syncs repeat only at multiples of eight
// - sync rates limited to n times eight
// - all-zero selects mean no pointer resets
// - dual mode: write and read reset separately
// - single mode: both pointers from one sync
// - single mode slip bounded, never grows
// - single mode prefers one rising sync edge
// - alarms for collision, one and two away
// - controller offset changes only by register write
// - bypass passes data, ignores pointers and syncs
// - selects 1000 use software issued sync
package daef_pkg;

  // ----------------------------------------
  // data path
  // ----------------------------------------
  localparam int DATA_W = 32;
  localparam int SAMP_W = 64;
  localparam int CH_W = 16;
  localparam int DEPTH = 8;
  localparam int PTR_W = 3;
  localparam logic [2:0] RD_PTR_RST = 3'h0;
  localparam logic [2:0] OFFSET_RST = 3'h4;

  // ----------------------------------------
  // sync source select fields
  // ----------------------------------------
  localparam int SEL_W = 4;
  localparam int SEL_FSYNC = 0;
  localparam int SEL_IN_STB = 1;
  localparam int SEL_OUT_STB = 2;
  localparam int SEL_SW = 3;
  localparam logic [3:0] SEL_NONE = 4'h0;
  localparam logic [3:0] SEL_SW_MODE = 4'h8;
  localparam logic [3:0] IN_SEL_RST = 4'h2;
  localparam logic [3:0] OUT_SEL_RST = 4'h4;

  // ----------------------------------------
  // timing in mclk cycles
  // ----------------------------------------
  localparam int HALF_CYC = 2;
  localparam int PER_CYC = 2 * HALF_CYC;
  localparam int PHASE_W = 2;
  localparam logic [3:0] RD_DIV_RST = 4'h4;
  localparam logic [3:0] STROBE_CYC = 4'h8;

  // ----------------------------------------
  // controller registers (axi4-lite)
  // ----------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CMD = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h8;
  localparam int CTRL_ENA = 0;
  localparam int CTRL_OFS = 1;
  localparam int CTRL_INSEL = 4;
  localparam int CTRL_OUTSEL = 8;
  localparam int CTRL_RDDIV = 12;
  localparam logic [15:0] CTRL_RST = {RD_DIV_RST, OUT_SEL_RST, IN_SEL_RST, OFFSET_RST, 1'b1};
  localparam int STAT_COLL = 0;
  localparam int STAT_ONE = 1;
  localparam int STAT_TWO = 2;
  localparam int STAT_BUSY = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: logic/daef_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface daef_link_if;
  // sample bus pins
  logic source_ddr_clock;
  logic [31:0] data;
  logic input_strobe;
  logic frame_sync;
  logic output_strobe;
  // control words
  logic fifo_ena;
  logic [2:0] fifo_offset;
  logic [3:0] sel_in;
  logic [3:0] sel_out;
  logic [3:0] rd_div;
  logic sw_sync;
  // alarms back to the controller
  logic alarm_collision;
  logic alarm_one_away;
  logic alarm_two_away;

  modport dev (
    input source_ddr_clock, data, input_strobe, frame_sync, output_strobe,
    input fifo_ena, fifo_offset, sel_in, sel_out, rd_div, sw_sync,
    output alarm_collision, alarm_one_away, alarm_two_away
  );
  modport src (
    output source_ddr_clock, data, input_strobe, frame_sync, output_strobe,
    output fifo_ena, fifo_offset, sel_in, sel_out, rd_div, sw_sync,
    input alarm_collision, alarm_one_away, alarm_two_away
  );
endinterface
`default_nettype wire

// File: logic/daef_src.sv
`timescale 1ns/1ps
`default_nettype none
module daef_src (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic [3:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [3:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [63:0] sample_i,
  input wire logic sample_valid_i,
  output logic sample_ready_o,
  daef_link_if.src link
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [daef_pkg::PHASE_W-1:0] cnt;
    logic clk;
    logic [31:0] data;
    logic [63:0] hold;
    logic ready;
    logic [3:0] strb_cnt;
    logic [3:0] strb_mask;
    logic [3:0] pins;
    logic [15:0] ctrl;
    logic aw_rdy;
    logic b_valid;
    logic [1:0] b_resp;
    logic ar_rdy;
    logic r_valid;
    logic [31:0] r_data;
    logic [1:0] r_resp;
  } daef_src_st_t;

  daef_src_st_t st_r;
  daef_src_st_t st_nxt;
  logic [daef_pkg::PHASE_W-1:0] cnt_n;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    cnt_n = st_r.cnt;
    if (srst_i) begin
      st_nxt = '0;
      st_nxt.ctrl = daef_pkg::CTRL_RST;
    end else if (ce_i) begin
      // data clock divider, one sample per period
      cnt_n = (st_r.cnt == daef_pkg::PHASE_W'(daef_pkg::PER_CYC - 1)) ?
              '0 : daef_pkg::PHASE_W'(st_r.cnt + 1'b1);
      st_nxt.cnt = cnt_n;
      st_nxt.ready = (cnt_n == daef_pkg::PHASE_W'(daef_pkg::PER_CYC - 1));
      if (st_r.ready && sample_valid_i) begin
        st_nxt.hold = sample_i;
      end
      // a and c with the rise, b and d with the fall
      if (cnt_n == '0) begin
        st_nxt.clk = 1'b1;
        st_nxt.data = {st_nxt.hold[47:32], st_nxt.hold[15:0]};
      end else if (cnt_n == daef_pkg::PHASE_W'(daef_pkg::HALF_CYC)) begin
        st_nxt.clk = 1'b0;
        st_nxt.data = {st_r.hold[63:48], st_r.hold[31:16]};
      end

      // strobe pulses last STROBE_CYC cycles
      if (st_r.strb_cnt != 4'h0) begin
        st_nxt.strb_cnt = 4'(st_r.strb_cnt - 4'h1);
      end

      // write channel: both address and data before acceptance
      st_nxt.aw_rdy = 1'b0;
      if (s_axi_awvalid_i && s_axi_wvalid_i && !st_r.aw_rdy && !st_r.b_valid) begin
        st_nxt.aw_rdy = 1'b1;
      end
      if (st_r.b_valid && s_axi_bready_i) begin
        st_nxt.b_valid = 1'b0;
      end
      if (st_r.aw_rdy) begin
        st_nxt.b_valid = 1'b1;
        st_nxt.b_resp = daef_pkg::RESP_OKAY;
        unique case (s_axi_awaddr_i)
          daef_pkg::ADDR_CTRL: begin
            if (s_axi_wstrb_i[0]) st_nxt.ctrl[7:0] = s_axi_wdata_i[7:0];
            if (s_axi_wstrb_i[1]) st_nxt.ctrl[15:8] = s_axi_wdata_i[15:8];
          end
          daef_pkg::ADDR_CMD: begin
            if (s_axi_wstrb_i[0]) begin
              st_nxt.strb_mask = s_axi_wdata_i[3:0];
              st_nxt.strb_cnt = daef_pkg::STROBE_CYC;
            end
          end
          daef_pkg::ADDR_STAT: begin
          end
          default: st_nxt.b_resp = daef_pkg::RESP_SLVERR;
        endcase
      end
      st_nxt.pins = (st_nxt.strb_cnt != 4'h0) ? st_nxt.strb_mask : 4'h0;

      // read channel
      st_nxt.ar_rdy = 1'b0;
      if (s_axi_arvalid_i && !st_r.ar_rdy && !st_r.r_valid) begin
        st_nxt.ar_rdy = 1'b1;
      end
      if (st_r.r_valid && s_axi_rready_i) begin
        st_nxt.r_valid = 1'b0;
      end
      if (st_r.ar_rdy) begin
        st_nxt.r_valid = 1'b1;
        st_nxt.r_resp = daef_pkg::RESP_OKAY;
        st_nxt.r_data = 32'h0000_0000;
        unique case (s_axi_araddr_i)
          daef_pkg::ADDR_CTRL: st_nxt.r_data[15:0] = st_r.ctrl;
          daef_pkg::ADDR_CMD: st_nxt.r_data[3:0] = st_r.strb_mask;
          daef_pkg::ADDR_STAT: st_nxt.r_data[3:0] = {st_r.strb_cnt != 4'h0,
            link.alarm_two_away, link.alarm_one_away, link.alarm_collision};
          default: st_nxt.r_resp = daef_pkg::RESP_SLVERR;
        endcase
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // state update
  always_ff @(posedge mclk_i) begin
    st_r <= st_nxt;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // bus answers and pins from state bits
  assign s_axi_awready_o = st_r.aw_rdy;
  assign s_axi_wready_o = st_r.aw_rdy;
  assign s_axi_bvalid_o = st_r.b_valid;
  assign s_axi_bresp_o = st_r.b_resp;
  assign s_axi_arready_o = st_r.ar_rdy;
  assign s_axi_rvalid_o = st_r.r_valid;
  assign s_axi_rdata_o = st_r.r_data;
  assign s_axi_rresp_o = st_r.r_resp;
  assign sample_ready_o = st_r.ready;
  assign link.source_ddr_clock = st_r.clk;
  assign link.data = st_r.data;
  assign link.input_strobe = st_r.pins[daef_pkg::SEL_IN_STB];
  assign link.frame_sync = st_r.pins[daef_pkg::SEL_FSYNC];
  assign link.output_strobe = st_r.pins[daef_pkg::SEL_OUT_STB];
  assign link.sw_sync = st_r.pins[daef_pkg::SEL_SW];
  assign link.fifo_ena = st_r.ctrl[daef_pkg::CTRL_ENA];
  assign link.fifo_offset = st_r.ctrl[daef_pkg::CTRL_OFS +: 3];
  assign link.sel_in = st_r.ctrl[daef_pkg::CTRL_INSEL +: 4];
  assign link.sel_out = st_r.ctrl[daef_pkg::CTRL_OUTSEL +: 4];
  assign link.rd_div = st_r.ctrl[daef_pkg::CTRL_RDDIV +: 4];

endmodule
`default_nettype wire

// File: tb/daef_props.sv
`timescale 1ns/1ps
`default_nettype none
module daef_props (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic source_ddr_clock,
  input wire logic [31:0] data,
  input wire logic input_strobe,
  input wire logic output_strobe,
  input wire logic fifo_ena,
  input wire logic [2:0] fifo_offset,
  input wire logic [3:0] sel_in,
  input wire logic [3:0] sel_out,
  input wire logic alarm_collision,
  input wire logic alarm_one_away,
  input wire logic alarm_two_away
);
  // cycles spent with the buffer bypassed, saturating
  logic [4:0] byp_cnt_r;
  logic [4:0] byp_cnt_nxt;
  always_comb begin
    byp_cnt_nxt = byp_cnt_r;
    if (fifo_ena) byp_cnt_nxt = 5'h00;
    else if (byp_cnt_r != 5'h1F) byp_cnt_nxt = byp_cnt_r + 5'h01;
  end
  always_ff @(posedge mclk_i) begin
    if (srst_i) byp_cnt_r <= 5'h00;
    else byp_cnt_r <= byp_cnt_nxt;
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  // ----------------------------------------
  // wire framing and control words
  // ----------------------------------------
  chk_clk_high_two: assert property (
    $rose(source_ddr_clock) |=> source_ddr_clock ##1 !source_ddr_clock)
    else $error("data clock high phase not two cycles");
  chk_clk_low_two: assert property (
    $fell(source_ddr_clock) |=> !source_ddr_clock ##1 source_ddr_clock)
    else $error("data clock low phase not two cycles");
  chk_half_hold: assert property (
    $changed(source_ddr_clock) |=> $stable(data))
    else $error("data half not held for its phase");
  chk_data_on_edge: assert property (
    $changed(data) |-> $changed(source_ddr_clock))
    else $error("data moved without a clock edge");
  chk_in_strobe_len: assert property (
    $rose(input_strobe) |=> input_strobe [*7] ##1 !input_strobe)
    else $error("input strobe pulse length wrong");
  chk_out_strobe_len: assert property (
    $rose(output_strobe) |=> output_strobe [*7] ##1 !output_strobe)
    else $error("output strobe pulse length wrong");
  chk_reset_ctrl_words: assert property (
    $fell(srst_i) |-> fifo_ena && fifo_offset == 3'h4 && sel_in == 4'h2 && sel_out == 4'h4)
    else $error("control words wrong after reset");

  // ----------------------------------------
  // alarms
  // ----------------------------------------
  chk_alarm_one_hot: assert property (
    $onehot0({alarm_collision, alarm_one_away, alarm_two_away}))
    else $error("more than one alarm at once");
  chk_bypass_quiet: assert property (
    byp_cnt_r >= 5'h14 |-> !(alarm_collision || alarm_one_away || alarm_two_away))
    else $error("alarm raised while bypassed");

  cover property (alarm_two_away);
  cover property ($rose(output_strobe));
  cover property (byp_cnt_r == 5'h14);
endmodule
`default_nettype wire

// File: tb/dac_input_elastic_fifo_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dac_input_elastic_fifo_tb;
  logic mclk_i;
  logic srst_i;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [63:0] smp, dout;
  logic smp_valid, smp_ready, dout_valid;
  logic [11:0] k_r;
  logic [2:0] o_coll;
  logic alm_coll, alm_one, alm_two;
  int err_total, check_count, cyc;

  daef_link_if u_daef_link_if ();
  daef_src u_daef_src (.mclk_i(mclk_i), .srst_i(srst_i), .ce_i(1'b1),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .sample_i(smp),
    .sample_valid_i(smp_valid), .sample_ready_o(smp_ready), .link(u_daef_link_if));
  daef_dev u_daef_dev (.mclk_i(mclk_i), .srst_i(srst_i), .ce_i(1'b1), .link(u_daef_link_if),
    .sample_o(dout), .sample_valid_o(dout_valid), .alarm_collision_o(alm_coll),
    .alarm_one_away_o(alm_one), .alarm_two_away_o(alm_two));
  daef_props u_daef_props (.mclk_i(mclk_i), .srst_i(srst_i),
    .source_ddr_clock(u_daef_link_if.source_ddr_clock), .data(u_daef_link_if.data),
    .input_strobe(u_daef_link_if.input_strobe), .output_strobe(u_daef_link_if.output_strobe),
    .fifo_ena(u_daef_link_if.fifo_ena), .fifo_offset(u_daef_link_if.fifo_offset),
    .sel_in(u_daef_link_if.sel_in), .sel_out(u_daef_link_if.sel_out),
    .alarm_collision(u_daef_link_if.alarm_collision),
    .alarm_one_away(u_daef_link_if.alarm_one_away),
    .alarm_two_away(u_daef_link_if.alarm_two_away));

  // ----------------------------------------
  // clock, sample source, hang guard
  // ----------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end
  // lane-tagged sample: D, C, B, A from top down
  function automatic logic [63:0] mk(input logic [11:0] k);
    mk = {4'hD, k, 4'hC, k, 4'hB, k, 4'hA, k};
  endfunction
  assign smp = mk(k_r);
  // next sample offered after each accepted one
  always @(posedge mclk_i) begin
    if (srst_i) k_r <= 12'h000;
    else if (smp_ready && smp_valid) k_r <= k_r + 12'h001;
  end
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      finish_test();
    end
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic finish_test();
    if (err_total == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_done;
    logic w_done;
    @(posedge mclk_i);
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk_i);
      aw_done |= (awready === 1'b1);
      w_done |= (wready === 1'b1);
      if (aw_done) awvalid <= 1'b0;
      if (w_done) wvalid <= 1'b0;
    end while (!(aw_done && w_done));
    do @(posedge mclk_i); while (bvalid !== 1'b1);
    chk("bresp", er, bresp);
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      do @(posedge mclk_i); while (dout_valid !== 1'b1);
    end
  endtask
  // one-shot strobes, issued at a fixed data clock phase
  task automatic sync(input logic [3:0] cmd);
    do @(posedge mclk_i); while (smp_ready !== 1'b1);
    axi_wr(daef_pkg::ADDR_CMD, {28'h0, cmd}, daef_pkg::RESP_OKAY);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // output must be the input samples, in order, lanes intact
  task automatic check_stream();
    logic [11:0] k;
    pulses(10);
    k = dout[11:0];
    for (int i = 0; i < 12; i++) begin
      chk("sample", mk(k), dout);
      k = k + 12'h001;
      pulses(1);
    end
  endtask
  // each offset shifts the gap by one: one collision, two each near alarms
  task automatic sweep(input logic [3:0] si, input logic [3:0] so, input logic [3:0] cmd);
    logic [31:0] s0, s1;
    logic [1:0] r;
    logic [3:0] n [3];
    n = '{4'h0, 4'h0, 4'h0};
    for (int o = 0; o < 8; o++) begin
      axi_wr(daef_pkg::ADDR_CTRL, {16'h0, 4'h4, so, si, 3'(o), 1'b1}, daef_pkg::RESP_OKAY);
      sync(cmd);
      pulses(8);
      axi_rd(daef_pkg::ADDR_STAT, s0, r);
      pulses(8);
      axi_rd(daef_pkg::ADDR_STAT, s1, r);
      chk("alarm steady", s0[2:0], s1[2:0]);
      chk("alarm pins", s1[2:0], {alm_two, alm_one, alm_coll});
      for (int b = 0; b < 3; b++) if (s0[b] === 1'b1) n[b] += 4'h1;
      if (s0[0] === 1'b1 && si == 4'h2 && so == 4'h4) o_coll = 3'(o);
    end
    chk("alarm counts", 12'h122, {n[0], n[1], n[2]});
  endtask
  // with both selects cleared a new sync must not move the pointers
  task automatic no_reset();
    logic [31:0] s0, s1;
    logic [1:0] r;
    axi_wr(daef_pkg::ADDR_CTRL, {16'h0, 12'h442, o_coll, 1'b1}, daef_pkg::RESP_OKAY);
    sync(4'h6);
    pulses(8);
    axi_rd(daef_pkg::ADDR_STAT, s0, r);
    chk("collision", 3'h1, s0[2:0]);
    axi_wr(daef_pkg::ADDR_CTRL, {16'h0, 12'h400, o_coll + 3'h3, 1'b1}, daef_pkg::RESP_OKAY);
    sync(4'hF);
    pulses(8);
    axi_rd(daef_pkg::ADDR_STAT, s1, r);
    chk("no resync", s0[2:0], s1[2:0]);
  endtask
  // bypass ignores a colliding offset, the frame sync and both strobes
  task automatic bypass();
    logic [31:0] s0;
    logic [1:0] r;
    axi_wr(daef_pkg::ADDR_CTRL, {16'h0, 12'h442, o_coll, 1'b0}, daef_pkg::RESP_OKAY);
    sync(4'h7);
    check_stream();
    axi_rd(daef_pkg::ADDR_STAT, s0, r);
    chk("bypass alarms", 3'h0, s0[2:0]);
    axi_rd(daef_pkg::ADDR_CMD, s0, r);
    chk("cmd mask", 32'h7, s0);
    axi_wr(daef_pkg::ADDR_CTRL, 32'h4429, daef_pkg::RESP_OKAY);
    sync(4'h6);
    check_stream();
  endtask

  // main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    srst_i = 1'b1;
    {awaddr, araddr, wstrb, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    smp_valid = 1'b1;
    o_coll = 3'h0;
    repeat (10) @(posedge mclk_i);
    srst_i <= 1'b0;
    axi_rd(daef_pkg::ADDR_CTRL, d, r);
    chk("ctrl reset", {16'h0, daef_pkg::CTRL_RST}, d);
    axi_rd(4'hC, d, r);
    chk("unmapped rresp", daef_pkg::RESP_SLVERR, r);
    axi_wr(4'hC, 32'h0, daef_pkg::RESP_SLVERR);
    check_stream();
    sweep(4'h2, 4'h4, 4'h6);
    sweep(4'h1, 4'h4, 4'h5);
    sweep(4'h2, 4'h2, 4'h2);
    sweep(4'h1, 4'h1, 4'h1);
    sweep(4'h8, 4'h8, 4'h8);
    no_reset();
    bypass();
    finish_test();
  end
endmodule
`default_nettype wire
